// [hw/pcm_pkg.sv]
// package with offsets, reset values and timing constants of the monitor registers
package pcm_pkg;
    // register offsets
    localparam logic [7:0] PCM_OFS_CURRENT = 8'h00;
    localparam logic [7:0] PCM_OFS_CHARGE3 = 8'h01;
    localparam logic [7:0] PCM_OFS_CHARGE2 = 8'h02;
    localparam logic [7:0] PCM_OFS_CHARGE1 = 8'h03;
    localparam logic [7:0] PCM_OFS_CHARGE0 = 8'h04;
    localparam logic [7:0] PCM_OFS_PIN_ACT = 8'h0f;
    localparam logic [7:0] PCM_OFS_FAULT = 8'h10;
    localparam logic [7:0] PCM_OFS_GENERAL = 8'h11;
    localparam logic [7:0] PCM_OFS_PROFILE_A = 8'h12;
    localparam logic [7:0] PCM_OFS_PROFILE_B = 8'h13;
    localparam logic [7:0] PCM_OFS_PIN_LEVEL = 8'h14;
    // field positions
    localparam int PCM_BIT_ALERT_MIRROR = 5;
    localparam int PCM_BIT_ATTACH_MIRROR = 4;
    localparam int PCM_BIT_CHARGING_ACTIVE = 3;
    localparam int PCM_BIT_POWER_UP = 5;
    localparam int PCM_BIT_ERROR = 7;
    localparam int PCM_CHARGE_LSB_POS = 6;
    // widths
    localparam int PCM_CURRENT_W = 8;
    localparam int PCM_CHARGE_W = 26;
    // values after reset
    localparam logic [7:0] PCM_RST_BYTE = 8'h00;
    localparam logic [25:0] PCM_RST_CHARGE = 26'h0000000;
    localparam logic PCM_RST_POWER_UP = 1'b1;
    // undefined addresses read as zero
    localparam logic [7:0] PCM_UNMAPPED_DATA = 8'h00;
    // timing: one accumulation step per second
    localparam int PCM_CLK_PERIOD_NS = 50;
    localparam int PCM_UPDATE_PERIOD_MS = 1000;
    localparam int PCM_UPDATE_CYCLES = (PCM_UPDATE_PERIOD_MS * 1000000) / PCM_CLK_PERIOD_NS;
endpackage

// [hw/pcm_acc_if.sv]
// interface joining the register bank and the charge accumulator
`timescale 1ns/10ps
`default_nettype none
interface pcm_acc_if;
    import pcm_pkg::*;
    logic active; // device in active power state
    logic enable; // rationing enabled
    logic clear; // rationing reset requested
    logic [PCM_CURRENT_W-1:0] current; // current code being delivered
    logic [PCM_CHARGE_W-1:0] threshold; // rationing threshold
    logic [PCM_CHARGE_W-1:0] charge; // accumulated charge
    logic reached; // charge at or above threshold
    logic updated; // one-cycle pulse per update
    modport acc (input active, enable, clear, current, threshold, output charge, reached, updated);
    modport ctl (output active, enable, clear, current, threshold, input charge, reached, updated);
endinterface
`default_nettype wire

// [hw/pcm_charge_acc.sv]
// once-per-second accumulated charge counter with threshold compare
`timescale 1ns/10ps
`default_nettype none
module pcm_charge_acc
    import pcm_pkg::*;
#(
    parameter int SECOND_CYCLES = PCM_UPDATE_CYCLES
)
(
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_in,
    // link to register bank
    pcm_acc_if.acc acc_io
);
    import pcm_pkg::*;

    // whole state of the accumulator
    typedef struct packed {
        logic [31:0] sec_cnt; // cycles into current second
        logic [PCM_CHARGE_W-1:0] charge; // accumulated charge
        logic reached; // compare result
        logic updated; // update pulse
    } pcm_acc_state_t;

    localparam logic [31:0] LAST_CYCLE = 32'(SECOND_CYCLES - 1);

    pcm_acc_state_t st_r; // registered state
    pcm_acc_state_t st_nxt; // next state
    logic [PCM_CHARGE_W:0] sum; // sum with carry for saturation

    // next-state logic
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.updated = 1'b0;
        sum = {1'b0, st_r.charge} + {{(PCM_CHARGE_W+1-PCM_CURRENT_W){1'b0}}, acc_io.current};
        if (acc_io.clear || !acc_io.enable)
        begin
            // the reset bit or a cleared enable bit clears the total, as does rst_in
            st_nxt.charge = PCM_RST_CHARGE;
            st_nxt.reached = 1'b0;
            st_nxt.sec_cnt = 32'h00000000;
        end
        else if (acc_io.active)
        begin
            // one current count over one second is about one charge count
            if (st_r.sec_cnt >= LAST_CYCLE)
            begin
                st_nxt.sec_cnt = 32'h00000000;
                // saturate rather than wrap, a wrapped total would defeat rationing
                st_nxt.charge = sum[PCM_CHARGE_W] ? {PCM_CHARGE_W{1'b1}} : sum[PCM_CHARGE_W-1:0];
                // compare each fresh total
                st_nxt.reached = (st_nxt.charge >= acc_io.threshold);
                st_nxt.updated = 1'b1;
            end
            else
            begin
                st_nxt.sec_cnt = st_r.sec_cnt + 32'h00000001;
            end
        end
        // outside active everything holds, resuming on return
    end

    // state register
    always_ff @(posedge sys_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign acc_io.charge = st_r.charge;
    assign acc_io.reached = st_r.reached;
    assign acc_io.updated = st_r.updated;
endmodule
`default_nettype wire

// [hw/pcm_monitor_regs.sv]
// port current and charge monitor register bank with status registers
`timescale 1ns/10ps
`default_nettype none
module pcm_monitor_regs
    import pcm_pkg::*;
#(
    parameter int SECOND_CYCLES = PCM_UPDATE_CYCLES
)
(
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_in,
    // register port
    input wire logic reg_rd_in,
    input wire logic reg_wr_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    output logic [7:0] reg_rdata_out,
    // power state and switch
    input wire logic active_state_in,
    input wire logic sleep_state_in,
    input wire logic detect_state_in,
    input wire logic switch_on_in,
    input wire logic port_power_enable_in,
    // measurement
    input wire logic [PCM_CURRENT_W-1:0] port_current_in,
    input wire logic [PCM_CURRENT_W-1:0] charging_current_threshold_in,
    // rationing control
    input wire logic rationing_enable_bit_in,
    input wire logic rationing_reset_bit_in,
    input wire logic [PCM_CHARGE_W-1:0] rationing_threshold_in,
    output logic rationing_reached_out,
    output logic charge_updated_out,
    // pin mirrors and other status sources
    input wire logic alert_asserted_in,
    input wire logic attach_detect_output_n_in,
    input wire logic [2:0] emulation_status_in,
    input wire logic [6:0] fault_status_in,
    input wire logic error_state_in,
    input wire logic [7:0] general_status_in,
    input wire logic [7:0] profile_state_a_in,
    input wire logic [7:0] profile_state_b_in,
    input wire logic [7:0] pin_level_status_in,
    // error clear request
    output logic error_clear_out
);
    import pcm_pkg::*;

    // whole state of the bank
    // kept in one struct so a single register process owns every flop
    // adding a field here needs no change to the reset branch
    // except where a field must come out of reset set
    typedef struct packed {
        logic [PCM_CURRENT_W-1:0] current; // port_current_now
        logic charging; // charging_active_flag
        logic power_up; // power-up flag of fault_event_status
        logic pe_prev; // last power enable level
        logic pe_seen; // pe_prev holds a real sample
        logic [7:0] rdata; // read data
        logic err_clr; // error clear pulse
    } pcm_bank_state_t;

    pcm_bank_state_t st_r; // registered state
    pcm_bank_state_t st_nxt; // next state
    logic [31:0] charge_word; // charge as the four byte registers see it
    logic [7:0] pin_act_byte; // pin_and_activity_status contents
    logic [7:0] fault_byte; // fault_event_status contents
    logic [7:0] rd_mux; // selected read value
    logic pe_toggle; // power enable changed level

    // the accumulator sits in its own module so its long second counter
    // can be shortened for simulation without touching the register map
    // it sees only levels, no register strobes
    pcm_acc_if acc_link ();

    // accumulator integrates the displayed current, so its total stops growing when the switch is off
    assign acc_link.active = active_state_in;
    assign acc_link.enable = rationing_enable_bit_in;
    assign acc_link.clear = rationing_reset_bit_in;
    assign acc_link.current = st_r.current;
    assign acc_link.threshold = rationing_threshold_in;

    pcm_charge_acc #(
        .SECOND_CYCLES(SECOND_CYCLES)
    ) u_charge_acc (
        .sys_clk_in(sys_clk_in),
        .rst_in(rst_in),
        .acc_io(acc_link)
    );

    // charge packed MSB first into bits 31..6, low six bits read zero
    assign charge_word = {acc_link.charge, 6'h00};

    // live pin mirrors and activity bits
    assign pin_act_byte = {2'h0, alert_asserted_in, !attach_detect_output_n_in, st_r.charging,
                           emulation_status_in};

    // fault bits follow their sources, power-up flag never reaches the alert pin
    assign fault_byte = {error_state_in, fault_status_in[6], st_r.power_up, fault_status_in[4:0]};

    // toggle detection waits one edge after reset, otherwise the reset
    // value of pe_prev would look like a change when power enable is high
    // power enable is a level from the same clock domain, no synchroniser
    assign pe_toggle = st_r.pe_seen && (port_power_enable_in != st_r.pe_prev);

    // read multiplexer
    // charge bytes come straight from the live total, there is no snapshot,
    // so a multi-byte read may straddle an update; software should read twice
    // and compare when it needs a coherent value
    // status sources other than the power-up flag and the charging flag are read live
    always_comb
    begin
        case (reg_addr_in)
            PCM_OFS_CURRENT: rd_mux = st_r.current;
            PCM_OFS_CHARGE3: rd_mux = charge_word[31:24];
            PCM_OFS_CHARGE2: rd_mux = charge_word[23:16];
            PCM_OFS_CHARGE1: rd_mux = charge_word[15:8];
            PCM_OFS_CHARGE0: rd_mux = charge_word[7:0];
            PCM_OFS_PIN_ACT: rd_mux = pin_act_byte;
            PCM_OFS_FAULT: rd_mux = fault_byte;
            PCM_OFS_GENERAL: rd_mux = general_status_in;
            PCM_OFS_PROFILE_A: rd_mux = profile_state_a_in;
            PCM_OFS_PROFILE_B: rd_mux = profile_state_b_in;
            PCM_OFS_PIN_LEVEL: rd_mux = pin_level_status_in;
            default: rd_mux = PCM_UNMAPPED_DATA;
        endcase
    end

    // next-state logic
    // sleep and detect win over the switch, which wins over a fresh sample
    // outside active with the switch on the last code simply holds
    // the charging flag compares the raw input, not the displayed code,
    // so it keeps working while the displayed value is forced to zero
    // read data changes only on a read strobe and then stands until the next
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.err_clr = 1'b0;
        st_nxt.pe_prev = port_power_enable_in;
        st_nxt.pe_seen = 1'b1;
        // current register
        if (sleep_state_in || detect_state_in)
        begin
            st_nxt.current = PCM_RST_BYTE;
        end
        else if (!switch_on_in)
        begin
            st_nxt.current = PCM_RST_BYTE;
        end
        else if (active_state_in)
        begin
            st_nxt.current = port_current_in;
        end
        // charging flag, equal current keeps the last decision
        if (port_current_in > charging_current_threshold_in)
        begin
            st_nxt.charging = 1'b1;
        end
        else if (port_current_in < charging_current_threshold_in)
        begin
            st_nxt.charging = 1'b0;
        end
        // read data captured on the strobe
        if (reg_rd_in)
        begin
            st_nxt.rdata = rd_mux;
        end
        // power-up flag cleared by reading it or by toggling power enable
        if ((reg_rd_in && (reg_addr_in == PCM_OFS_FAULT)) || pe_toggle)
        begin
            st_nxt.power_up = 1'b0;
        end
        // only the error bit is writable, writing zero asks for error recovery
        if (reg_wr_in && (reg_addr_in == PCM_OFS_FAULT) && !reg_wdata_in[PCM_BIT_ERROR])
        begin
            st_nxt.err_clr = 1'b1;
        end
        // other writes have no effect
    end

    // state register, power-up flag comes out of reset set
    // only constants in the reset branch; the flag is the one field not zero
    // a glitch on rst_in reloads the flag, which software then sees as a reset
    always_ff @(posedge sys_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            st_r <= '0;
            st_r.power_up <= PCM_RST_POWER_UP;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // outputs
    // read data and the error clear pulse come from flops
    // reached and updated are already registered in the accumulator
    // error_clear_out is a request only, recovery itself lives elsewhere
    assign reg_rdata_out = st_r.rdata;
    assign rationing_reached_out = acc_link.reached;
    assign charge_updated_out = acc_link.updated;
    assign error_clear_out = st_r.err_clr;
endmodule
`default_nettype wire

// [bench/pcm_monitor.sv]
// concurrent checks on the monitor register bank ports
`timescale 1ns/10ps
`default_nettype none
module pcm_monitor
    import pcm_pkg::*;
(
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_in,
    // register port
    input wire logic reg_rd_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_rdata_out,
    // state and sources
    input wire logic active_state_in,
    input wire logic sleep_state_in,
    input wire logic switch_on_in,
    input wire logic rationing_enable_bit_in,
    input wire logic rationing_reset_bit_in,
    input wire logic alert_asserted_in,
    input wire logic attach_detect_output_n_in,
    // accumulator results
    input wire logic rationing_reached_out,
    input wire logic charge_updated_out
);
    default clocking mon_cb @(posedge sys_clk_in);
    endclocking
    default disable iff (rst_in);
    // one read request at a given place
    sequence rd_at(logic [7:0] a);
        reg_rd_in && reg_addr_in == a;
    endsequence
    a_unmapped_zero:
        assert property (reg_rd_in && (reg_addr_in > 8'h14 || (reg_addr_in > 8'h04 && reg_addr_in < 8'h0f))
            |=> reg_rdata_out == 8'h00) else $error("unmapped read not zero");
    a_sleep_zero:
        assert property (sleep_state_in [*2] ##0 rd_at(PCM_OFS_CURRENT) |=> reg_rdata_out == 8'h00)
            else $error("current not zero in sleep");
    a_switch_zero:
        assert property (!switch_on_in [*2] ##0 rd_at(PCM_OFS_CURRENT) |=> reg_rdata_out == 8'h00)
            else $error("current not zero with switch off");
    a_alert_mirror:
        assert property (rd_at(PCM_OFS_PIN_ACT) |=> reg_rdata_out[5] == $past(alert_asserted_in))
            else $error("alert mirror wrong");
    a_attach_mirror:
        assert property (rd_at(PCM_OFS_PIN_ACT) |=> reg_rdata_out[4] == !$past(attach_detect_output_n_in))
            else $error("attach mirror wrong");
    a_idle_no_update:
        assert property (!active_state_in |=> !charge_updated_out) else $error("update while not active");
    a_clear_holds:
        assert property ((rationing_reset_bit_in || !rationing_enable_bit_in) [*2]
            |-> !rationing_reached_out && !charge_updated_out) else $error("charge not held clear");
    a_powerup_once:
        assert property (rd_at(PCM_OFS_FAULT) ##2 rd_at(PCM_OFS_FAULT) |=> !reg_rdata_out[5])
            else $error("power-up flag not cleared by read");
endmodule
bind pcm_monitor_regs pcm_monitor pcm_monitor_i (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .reg_rd_in(reg_rd_in),
    .reg_addr_in(reg_addr_in), .reg_rdata_out(reg_rdata_out), .active_state_in(active_state_in),
    .sleep_state_in(sleep_state_in), .switch_on_in(switch_on_in), .rationing_enable_bit_in(rationing_enable_bit_in),
    .rationing_reset_bit_in(rationing_reset_bit_in), .alert_asserted_in(alert_asserted_in),
    .attach_detect_output_n_in(attach_detect_output_n_in), .rationing_reached_out(rationing_reached_out),
    .charge_updated_out(charge_updated_out));
`default_nettype wire

// [bench/pcm_host_model.sv]
// host-side register port model
`timescale 1ns/10ps
`default_nettype none
module pcm_host_model
(
    // clock
    input wire logic sys_clk_in,
    // register port
    output logic reg_rd_out,
    output logic reg_wr_out,
    output logic [7:0] reg_addr_out,
    output logic [7:0] reg_wdata_out,
    input wire logic [7:0] reg_rdata_in
);
    initial
        {reg_rd_out, reg_wr_out, reg_addr_out, reg_wdata_out} = '0;
    // one access: strobe for one edge, then address and data are scrambled;
    // read data is taken mid-cycle, once it has settled after the sampling edge
    task automatic acc(input logic wr, input logic [7:0] a, input logic [7:0] w, output logic [7:0] d);
        @(posedge sys_clk_in);
        {reg_rd_out, reg_wr_out, reg_addr_out, reg_wdata_out} <= {!wr, wr, a, w};
        @(posedge sys_clk_in);
        {reg_rd_out, reg_wr_out, reg_addr_out, reg_wdata_out} <= {2'h0, ~a, ~w};
        @(negedge sys_clk_in);
        d = reg_rdata_in;
    endtask
endmodule
`default_nettype wire

// [bench/pcm_monitor_regs_bench.sv]
// self-checking bench for the monitor register bank
`timescale 1ns/10ps
`default_nettype none
module pcm_monitor_regs_bench;
    import pcm_pkg::*;
    logic sys_clk_in, rst_in, act, slp, det, sw, en, rb, al, an, reg_rd, reg_wr, upd, reach;
    logic m_upd, m_reach, m_flag, m_pu, m_pe, m_ps, m_ec, pe, ec, er;
    logic [2:0] em;
    logic [6:0] fs;
    logic [7:0] reg_addr, reg_wdata, rdata, cur, thrc, m_cur, m_cnt, d;
    logic [25:0] thr, m_chg;
    logic [31:0] st, r;
    // read order: mapped places, the power-up flag twice, some holes
    logic [7:0] alist [16] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h0f, 8'h10, 8'h10, 8'h11, 8'h12, 8'h13,
        8'h14, 8'h05, 8'h0e, 8'h15, 8'hfd};
    int seed = 95;
    int err_total, compares, cyc;
    initial
    begin
        sys_clk_in = 1'h0;
        forever #25 sys_clk_in = ~sys_clk_in;
    end
    pcm_host_model pcm_host_model_i (.sys_clk_in(sys_clk_in), .reg_rd_out(reg_rd), .reg_wr_out(reg_wr),
        .reg_addr_out(reg_addr), .reg_wdata_out(reg_wdata), .reg_rdata_in(rdata));
    pcm_monitor_regs #(.SECOND_CYCLES(8)) pcm_monitor_regs_i (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
        .reg_rd_in(reg_rd), .reg_wr_in(reg_wr), .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata),
        .reg_rdata_out(rdata), .active_state_in(act), .sleep_state_in(slp), .detect_state_in(det),
        .switch_on_in(sw), .port_power_enable_in(pe), .port_current_in(cur), .charging_current_threshold_in(thrc),
        .rationing_enable_bit_in(en), .rationing_reset_bit_in(rb), .rationing_threshold_in(thr),
        .rationing_reached_out(reach), .charge_updated_out(upd), .alert_asserted_in(al),
        .attach_detect_output_n_in(an), .emulation_status_in(em), .fault_status_in(fs), .error_state_in(er),
        .general_status_in(st[31:24]), .profile_state_a_in(st[23:16]), .profile_state_b_in(st[15:8]),
        .pin_level_status_in(st[7:0]), .error_clear_out(ec));
    // reference model: current register, per-second sums, flags
    always @(posedge sys_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            {m_upd, m_reach, m_flag, m_cur, m_cnt, m_chg, m_pe, m_ps, m_ec} = '0;
            m_pu = 1'h1;
        end
        else
        begin
            m_upd = 1'h0;
            m_ec = reg_wr && reg_addr == PCM_OFS_FAULT && !reg_wdata[7];
            m_pu = m_pu & !(reg_rd && reg_addr == PCM_OFS_FAULT) & !(m_ps && pe != m_pe);
            m_pe = pe;
            m_ps = 1'h1;
            m_flag = (cur > thrc) | (m_flag & (cur == thrc));
            if (!en || rb)
                {m_cnt, m_chg, m_reach} = '0;
            else if (act)
                m_cnt = m_cnt + 8'h01;
            if (m_cnt == 8'h08)
            begin
                {m_cnt, m_upd} = 9'h001;
                m_chg = m_chg + m_cur;
                m_reach = (m_chg >= thr);
            end
            if (slp || det || !sw)
                m_cur = 8'h00;
            else if (act)
                m_cur = cur;
        end
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp)
        begin
            err_total++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic end_sim;
        $display("compares %0d errors %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // whole register image, charge bytes high first
    function automatic logic [7:0] exp_reg(input logic [7:0] a);
        logic [31:0] sb, cb;
        logic [167:0] img;
        sb = {<<8{st}};
        cb = {<<8{{m_chg, 6'h00}}};
        img = {sb, er, fs[6], m_pu, fs[4:0], 2'h0, al, ~an, m_flag, em, 80'h0, cb, m_cur};
        return (a > 8'h14) ? 8'h00 : img[a*8 +: 8];
    endfunction
    // expectation taken before each read so read side effects do not leak in
    task automatic sweep;
        logic [7:0] e, g;
        for (int k = 0; k < 16; k++)
        begin
            e = exp_reg(alist[k]);
            pcm_host_model_i.acc(1'h0, alist[k], 8'h00, g);
            chk(g, e);
        end
    endtask
    // result outputs every cycle, plus the hang guard
    always @(negedge sys_clk_in)
    begin
        cyc++;
        if (!rst_in)
            chk({5'h00, ec, reach, upd}, {5'h00, m_ec, m_reach, m_upd});
        if (cyc == 5000)
        begin
            err_total++;
            end_sim();
        end
    end
    initial
    begin
        rst_in = 1'h1;
        {act, slp, det, sw, en, rb, al, cur, thrc, thr, st, em, fs, er} = '0;
        {an, pe} = 2'h3;
        repeat (16) @(posedge sys_clk_in);
        rst_in <= 1'h0;
        sweep();
        repeat (40)
        begin
            r = $random(seed);
            @(posedge sys_clk_in);
            {act, slp, det, sw, al, an} <= {r[10], r[11] & r[12], r[13] & r[14], r[15] | r[16], r[3], r[9]};
            {cur, thrc} <= r[31:16];
            st <= {r[15:0], r[31:16]};
            {em, fs, er} <= {r[2:0], r[22:16], r[31]};
            repeat (3) @(posedge sys_clk_in);
            sweep();
        end
        // accumulate, pause, resume mid-second, clear, disable
        for (int p = 0; p < 4; p++)
        begin
            @(posedge sys_clk_in);
            {act, en, rb, sw, slp, det, cur} <= {1'h1, p != 3, p == 2, 3'h4, 8'hff};
            thr <= 26'h2fd;
            repeat (23) @(posedge sys_clk_in);
            act <= 1'h0;
            repeat (2) @(posedge sys_clk_in);
            sweep();
        end
        pcm_host_model_i.acc(1'h1, 8'h20, 8'hff, d);
        pcm_host_model_i.acc(1'h1, PCM_OFS_CURRENT, 8'h7e, d);
        pcm_host_model_i.acc(1'h1, PCM_OFS_FAULT, 8'h80, d);
        pcm_host_model_i.acc(1'h1, PCM_OFS_FAULT, 8'h00, d);
        sweep();
        // second reset in mid-run, then a power enable toggle clears the flag
        @(posedge sys_clk_in);
        rst_in <= 1'h1;
        repeat (2) @(posedge sys_clk_in);
        rst_in <= 1'h0;
        @(posedge sys_clk_in);
        pe <= 1'h0;
        repeat (2) @(posedge sys_clk_in);
        sweep();
        end_sim();
    end
endmodule
`default_nettype wire
